// ### hw/dcpa_defines.svh
/*
 * Constants of the configuration access port: widths, depth, reset
 * values and cycle counts.
 * Assumes it is included by bare name, once per compilation unit or
 * guarded as below.
 */
`ifndef DCPA_DEFINES_SVH
`define DCPA_DEFINES_SVH

// ===========================================================================
// Access port shape
`define DCPA_ADDR_W 10
`define DCPA_DATA_W 16
`define DCPA_DEPTH 1024

// Value returned for a location that has never been written.
`define DCPA_CFG_DFLT 16'h0000

// ===========================================================================
// Timing, in port clock cycles
// Edges from the accepting edge to the cycle in which ready is high.
`define DCPA_ACK_LAT 2
// Consecutive high cycles of reconfig done that trigger a reset.
`define DCPA_DONE_MIN 2'h2
`define DCPA_DONE_CNT_W 2
// Length of the transceiver reset pulse.
`define DCPA_XRST_CYC 3'h4
`define DCPA_XRST_CNT_W 3

`endif

// ### hw/dcpa_pkg.sv
/*
 * Types of the configuration access port: request and response carriers
 * and the shared read-value function.
 * Assumes dcpa_defines.svh is on the include path.
 */
`include "dcpa_defines.svh"

package dcpa_pkg;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic en;
    logic wr;
    logic [`DCPA_ADDR_W-1:0] addr;
    logic [`DCPA_DATA_W-1:0] cfg_write_data;
  } dcpa_req_t;

  typedef struct packed {
    logic ready;
    logic [`DCPA_DATA_W-1:0] rd_data;
  } dcpa_rsp_t;

  // Unwritten locations read back as the default value.
  function automatic logic [`DCPA_DATA_W-1:0] dcpa_fetch(
    input logic vld,
    input logic [`DCPA_DATA_W-1:0] word
  );
    return vld ? word : `DCPA_CFG_DFLT;
  endfunction

endpackage

// ### hw/dcpa_port.sv
/*
 * Configuration access port: single-cycle read and write requests into a
 * 1024 x 16 configuration store, a ready strobe with read data, and the
 * transceiver reset that follows the reconfiguration-done handshake.
 * Assumes all inputs come from user logic on mclk_i, so none is
 * synchronised, and that the requester keeps one request outstanding.
 */
// Function
// - Enable high starts access; low does nothing. Here enable high in the cycle after a taken request is dropped.
// - Write-select high writes, low reads.
// - Ready marks write done or read data valid.
// - 10-bit address, 16-bit write and read data.

`include "dcpa_defines.svh"

module dcpa_port (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire dcpa_pkg::dcpa_req_t req_i,
  input wire logic xcvr_reconfig_done_i,
  output dcpa_pkg::dcpa_rsp_t rsp_o,
  output logic xcvr_reset_o
);
  import dcpa_pkg::*;

  // ==========================================================
  // Request acceptance

  // Stage flag: high in the cycle after a request was taken.
  logic stg_r;
  // Copy of the request being served; stands until the next one is taken.
  dcpa_req_t req_r;
  // A request is taken whenever enable is high and the stage is free.
  logic acc;

  // A request that arrives while the stage is busy is dropped silently,
  // which is why the requester must wait for ready before the next one.
  assign acc = req_i.en && !stg_r;

  // Capture the whole request so the input may change right after.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      req_r <= '0;
    end else if (acc) begin
      req_r <= req_i;
    end
  end

  // One stage of latency between acceptance and completion.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      stg_r <= 1'b0;
    end else begin
      stg_r <= acc;
    end
  end

  // ==========================================================
  // Configuration store

  // The array has no reset; a valid bit per word stands in for it.
  logic [`DCPA_DATA_W-1:0] cfg_mem [0:`DCPA_DEPTH-1];
  logic [`DCPA_DEPTH-1:0] valid_r;

  // Write the stored word in the stage cycle of a write.
  always_ff @(posedge mclk_i) begin
    if (stg_r && req_r.wr) begin
      cfg_mem[req_r.addr] <= req_r.cfg_write_data;
    end
  end

  // Mark written words so unwritten ones read back as the default.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      valid_r <= '0;
    end else if (stg_r && req_r.wr) begin
      valid_r[req_r.addr] <= 1'b1;
    end
  end

  // ==========================================================
  // Response

  // Ready pulses one cycle per taken request; read data stands until
  // the next read completes, a write leaves it untouched.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rsp_o.ready <= 1'b0;
      rsp_o.rd_data <= `DCPA_CFG_DFLT;
    end else begin
      rsp_o.ready <= stg_r;
      if (stg_r && !req_r.wr) begin
        rsp_o.rd_data <= dcpa_fetch(valid_r[req_r.addr],
                                    cfg_mem[req_r.addr]);
      end
    end
  end

  // ==========================================================
  // Transceiver reset after reconfiguration

  logic [`DCPA_DONE_CNT_W-1:0] done_cnt_r;
  logic [`DCPA_XRST_CNT_W-1:0] xrst_cnt_r;
  logic xrst_fire;

  // Fire once per high stretch, when it reaches the least length. A
  // stretch that completes while a reset is still running is ignored so
  // the pulse keeps a fixed width.
  assign xrst_fire = xcvr_reconfig_done_i && !xcvr_reset_o &&
                     (done_cnt_r == `DCPA_DONE_MIN - 2'h1);

  // Count consecutive high cycles, saturating at the least length.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      done_cnt_r <= '0;
    end else if (!xcvr_reconfig_done_i) begin
      done_cnt_r <= '0;
    end else if (done_cnt_r != `DCPA_DONE_MIN) begin
      done_cnt_r <= done_cnt_r + 2'h1;
    end
  end

  // Drive the reset high for a fixed number of cycles.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      xrst_cnt_r <= '0;
      xcvr_reset_o <= 1'b0;
    end else if (xrst_fire) begin
      xrst_cnt_r <= `DCPA_XRST_CYC;
      xcvr_reset_o <= 1'b1;
    end else if (xrst_cnt_r > 3'h1) begin
      xrst_cnt_r <= xrst_cnt_r - 3'h1;
    end else begin
      xrst_cnt_r <= '0;
      xcvr_reset_o <= 1'b0;
    end
  end

  // ==========================================================
  // Checks

  default clocking chk_cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  localparam int ACK_LAT = `DCPA_ACK_LAT;

  // Last completed write, kept only so read-back can be checked.
  logic lw_vld_r;
  logic [`DCPA_ADDR_W-1:0] lw_addr_r;
  logic [`DCPA_DATA_W-1:0] lw_data_r;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      lw_vld_r <= 1'b0;
      lw_addr_r <= '0;
      lw_data_r <= '0;
    end else if (stg_r && req_r.wr) begin
      lw_vld_r <= 1'b1;
      lw_addr_r <= req_r.addr;
      lw_data_r <= req_r.cfg_write_data;
    end
  end

  // Every taken request is answered a fixed number of cycles later.
  ack_latency_a: assert property (
    acc |-> ##ACK_LAT rsp_o.ready
  ) else $error("ready missing after accepted request");

  // Ready never appears without an enabled request behind it.
  ready_cause_a: assert property (
    rsp_o.ready |-> $past(req_i.en, ACK_LAT) && $past(acc, ACK_LAT)
  ) else $error("ready without a request");

  // Ready is a single-cycle strobe.
  ready_pulse_a: assert property (
    rsp_o.ready |=> !rsp_o.ready
  ) else $error("ready held longer than one cycle");

  // A read of the last written address returns the written word.
  wr_readback_a: assert property (
    rsp_o.ready && !req_r.wr && lw_vld_r && (req_r.addr == lw_addr_r)
      |-> rsp_o.rd_data == lw_data_r
  ) else $error("read back differs from written data");

  // Completing a write leaves the read data alone.
  wr_keeps_rdata_a: assert property (
    stg_r && req_r.wr |=> $stable(rsp_o.rd_data)
  ) else $error("write disturbed read data");

  // A request during the busy stage is not taken.
  busy_drop_a: assert property (
    req_i.en && stg_r |=> $stable(req_r) ##1 !rsp_o.ready
  ) else $error("request taken while busy");

  // Two consecutive done cycles start the transceiver reset.
  xrst_trigger_a: assert property (
    $rose(xcvr_reset_o) |-> $past(xcvr_reconfig_done_i, 1) &&
      $past(xcvr_reconfig_done_i, 2)
  ) else $error("transceiver reset without done handshake");

  // The reset pulse has a fixed width of four cycles.
  xrst_width_a: assert property (
    $rose(xcvr_reset_o) |-> xcvr_reset_o [*4] ##1 !xcvr_reset_o
  ) else $error("transceiver reset width wrong");

  // Read data stands unless a read completes in this cycle.
  rdata_hold_a: assert property (
    !(stg_r && !req_r.wr) |=> $stable(rsp_o.rd_data)
  ) else $error("read data moved without a read");

  // A one-cycle done pulse never starts the transceiver reset.
  short_done_a: assert property (
    !xcvr_reset_o && $rose(xcvr_reconfig_done_i) ##1 !xcvr_reconfig_done_i
      |-> !xcvr_reset_o ##1 !xcvr_reset_o
  ) else $error("transceiver reset after a one-cycle done");

  // Main scenarios.
  read_done_c: cover property (acc && !req_i.wr ##ACK_LAT rsp_o.ready);
  write_done_c: cover property (acc && req_i.wr ##ACK_LAT rsp_o.ready);
  xrst_c: cover property (xcvr_reconfig_done_i [*2] ##1 xcvr_reset_o);
  refused_c: cover property (req_i.en && stg_r);

endmodule // dcpa_port

// ### bench/dcpa_user.sv
/* Requester model of the user logic that drives the access port.
   Assumes the port answers on mclk_i and keeps one request open. */
module dcpa_user (
  input wire logic mclk_i,
  input wire dcpa_pkg::dcpa_rsp_t rsp_i,
  output dcpa_pkg::dcpa_req_t req_o,
  output logic done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import dcpa_pkg::*;
  // ==========================================================
  // Requests
  // Both lines start low so nothing is taken during reset.
  initial begin
    req_o = '0;
    done_o = 1'b0;
  end
  // Strobes last one cycle; released fields are inverted so a
  // stale address or word can never pass for a held one.
  task automatic access(input logic wr, input logic [9:0] a,
    input logic [15:0] d, output logic [15:0] q, output int lat);
    @(posedge mclk_i);
    req_o <= '{1'b1, wr, a, d};
    @(posedge mclk_i);
    req_o <= '{1'b0, 1'b0, ~a, ~d};
    lat = 0;
    q = 'x;
    for (int i = 2; i < 10 && lat == 0; i++) begin
      @(posedge mclk_i);
      if (rsp_i.ready === 1'b1) begin
        lat = i;
        q = rsp_i.rd_data;
      end
    end
  endtask
  // Write-select with enable low must not touch the store.
  task automatic idle(input logic [9:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    req_o <= '{1'b0, 1'b1, a, d};
    @(posedge mclk_i);
    req_o <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  // Done stretch of n cycles after reconfiguration writes.
  task automatic done_pulse(input int n);
    @(posedge mclk_i);
    done_o <= 1'b1;
    repeat (n) @(posedge mclk_i);
    done_o <= 1'b0;
  endtask
  // Read held two cycles on purpose to probe the busy refusal; the
  // second cycle must be dropped, so only one answer may come.
  task automatic held_read(input logic [9:0] a);
    @(posedge mclk_i);
    req_o <= '{1'b1, 1'b0, a, 16'h0000};
    repeat (2) @(posedge mclk_i);
    req_o <= '{1'b0, 1'b0, ~a, 16'hffff};
  endtask
endmodule // dcpa_user

// ### bench/testbench.sv
/* Self-checking bench of the configuration access port.
   Assumes the defines header is on the include path. */
`include "dcpa_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dcpa_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  // Low stops the clock at ground, as an unused port may see it.
  logic clk_run = 1'b1;
  dcpa_req_t req;
  dcpa_rsp_t rsp;
  logic done;
  logic xrst;
  int fails = 0;
  int checked = 0;
  // ==========================================================
  // Clock, design and requester
  always #5 mclk_i = ~mclk_i & clk_run;
  dcpa_port DUT (.mclk_i(mclk_i), .reset_i(reset_i), .req_i(req),
    .xcvr_reconfig_done_i(done), .rsp_o(rsp), .xcvr_reset_o(xrst));
  dcpa_user u_user (.mclk_i(mclk_i), .rsp_i(rsp), .req_o(req),
    .done_o(done));
  // Case inequality so an unknown never passes as a match.
  task automatic chk(input string n, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic results();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  // Both end words and one inner word of the address range, written then read back.
  task automatic t_store();
    logic [15:0] q;
    int lat;
    logic [9:0] a [3] = '{10'h000, 10'h3ff, 10'h155};
    logic [15:0] d [3] = '{16'ha5a5, 16'hffff, 16'h0001};
    u_user.access(1'b0, 10'h2aa, 16'h0000, q, lat);
    chk("unwritten", `DCPA_CFG_DFLT, q);
    for (int i = 0; i < 3; i++) begin
      u_user.access(1'b1, a[i], d[i], q, lat);
      chk("wr lat", 16'(`DCPA_ACK_LAT + 1), 16'(lat));
    end
    for (int i = 0; i < 3; i++) begin
      u_user.access(1'b0, a[i], 16'h0000, q, lat);
      chk("rd data", d[i], q);
      chk("rd lat", 16'(`DCPA_ACK_LAT + 1), 16'(lat));
    end
    u_user.access(1'b1, a[0], 16'h0f0f, q, lat);
    chk("rd hold", d[2], rsp.rd_data);
  endtask
  // Enable low with write-select high: no answer, no write.
  task automatic t_idle();
    logic [15:0] q;
    int lat;
    int seen = 0;
    u_user.idle(10'h000, 16'h1234);
    repeat (4) begin
      @(posedge mclk_i);
      if (rsp.ready !== 1'b0) seen++;
    end
    chk("idle ready", 16'h0000, 16'(seen));
    u_user.access(1'b0, 10'h000, 16'h0000, q, lat);
    chk("idle store", 16'h0f0f, q);
  endtask
  // Short, minimum and long done stretches.
  task automatic t_done();
    int c;
    int n [3] = '{1, 2, 5};
    logic [15:0] e [3] = '{16'h0000, 16'h0004, 16'h0004};
    for (int i = 0; i < 3; i++) begin
      c = 0;
      fork
        u_user.done_pulse(n[i]);
        repeat (14) begin
          @(posedge mclk_i);
          if (xrst === 1'b1) c++;
        end
      join
      chk("xrst cycles", e[i], 16'(c));
    end
  endtask
  // Read held two cycles: one answer only, with the stored word.
  task automatic t_busy();
    int seen = 0;
    logic [15:0] q = 16'h0000;
    fork
      u_user.held_read(10'h000);
      repeat (8) begin
        @(posedge mclk_i);
        if (rsp.ready === 1'b1) begin
          seen++;
          q = rsp.rd_data;
        end
      end
    join
    chk("busy ready", 16'h0001, 16'(seen));
    chk("busy data", 16'h0f0f, q);
  endtask
  // Clock held at ground while idle: outputs stand, and the port
  // answers normally once the clock runs again.
  task automatic t_gnd();
    logic [15:0] q;
    int lat;
    @(posedge mclk_i);
    clk_run <= 1'b0;
    #100;
    chk("gnd ready", 16'h0000, {15'h0000, rsp.ready});
    chk("gnd rdata", 16'h0f0f, rsp.rd_data);
    chk("gnd xrst", 16'h0000, {15'h0000, xrst});
    clk_run <= 1'b1;
    u_user.access(1'b0, 10'h000, 16'h0000, q, lat);
    chk("gnd read", 16'h0f0f, q);
  endtask
  // Reset in mid-run: outputs go idle and the store reads default.
  task automatic t_reset();
    logic [15:0] q;
    int lat;
    @(posedge mclk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    chk("rst ready", 16'h0000, {15'h0000, rsp.ready});
    chk("rst rdata", `DCPA_CFG_DFLT, rsp.rd_data);
    chk("rst xrst", 16'h0000, {15'h0000, xrst});
    reset_i <= 1'b0;
    u_user.access(1'b0, 10'h000, 16'h0000, q, lat);
    chk("rst store", `DCPA_CFG_DFLT, q);
  endtask
  // ==========================================================
  // Sequence and watchdog
  initial begin
    repeat (4) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_store();
    t_idle();
    t_busy();
    t_gnd();
    t_reset();
    t_done();
    results();
  end
  // All scenarios need well under 300 cycles.
  initial begin
    #50us;
    fails++;
    results();
  end
endmodule // testbench
